//--- icsc_defines.svh
// Constants of the clock source unit: register offsets, field positions, reset values, timing.
// Assumes the includer compiles the 50 MHz single-clock design that uses them.
`ifndef ICSC_DEFINES_SVH
`define ICSC_DEFINES_SVH

`define ICSC_ADDR_CTRL1 8'h00
`define ICSC_ADDR_CTRL2 8'h01
`define ICSC_ADDR_TRIM 8'h02
`define ICSC_ADDR_STAT 8'h03

`define ICSC_C1_CS_MSB 7
`define ICSC_C1_CS_LSB 6
`define ICSC_C1_RDIV_MSB 5
`define ICSC_C1_RDIV_LSB 3
`define ICSC_C1_REFSEL 2
`define ICSC_C1_IRCLKEN 1
`define ICSC_C1_IRSTEN 0

`define ICSC_C2_BUSDIV_MSB 7
`define ICSC_C2_BUSDIV_LSB 6
`define ICSC_C2_RANGE 5
`define ICSC_C2_GAIN 4
`define ICSC_C2_PWRDN 3
`define ICSC_C2_OSCREQ 2
`define ICSC_C2_EREN 1
`define ICSC_C2_ERSTEN 0

`define ICSC_ST_FINE 0
`define ICSC_ST_LOCK 1
`define ICSC_ST_MODE_MSB 4
`define ICSC_ST_MODE_LSB 2
`define ICSC_ST_DMX32 5
`define ICSC_ST_OSCRNG_MSB 7
`define ICSC_ST_OSCRNG_LSB 6

`define ICSC_CTRL1_RST 8'h04
`define ICSC_CTRL2_RST 8'h40
`define ICSC_FACTORY_COARSE 8'h80
`define ICSC_FACTORY_FINE 1'h0
`define ICSC_OSCRNG_RST 2'h0

`define ICSC_CLK_MHZ 50
`define ICSC_ACQ_TIME_US 1
`define ICSC_ACQ_CYCLES (`ICSC_ACQ_TIME_US * `ICSC_CLK_MHZ)

`define ICSC_OSC_LOW_RATIO 11'h008
`define ICSC_OSC_MID_RATIO 11'h004
`define ICSC_OSC_HIGH_RATIO 11'h001
`define ICSC_DEBUG_RATIO 11'h002
`define ICSC_RDIV_HI_BASE 11'h020
`define ICSC_RDIV_HI_MAX 11'h400

`endif

//--- icsc_pkg.sv
// Types shared by the clock source unit.
// Assumes the defines header carries every numeric constant.
package icsc_pkg;

  // Gray codes along the engaged, bypassed and low-power modes; stop sits off to the side.
  typedef enum logic [2:0] {
    FLL_ENGAGED_INT_MODE = 3'h0,
    FLL_ENGAGED_EXT_MODE = 3'h1,
    FLL_BYPASSED_INT_MODE = 3'h3,
    BYPASSED_INT_LOWPOWER_MODE = 3'h2,
    FLL_BYPASSED_EXT_MODE = 3'h6,
    BYPASSED_EXT_LOWPOWER_MODE = 3'h7,
    STOP_MODE = 3'h5
  } icsc_mode_type;

endpackage

//--- icsc_sync3.sv
// Three-stage synchroniser with a rising-edge pulse for a pin-driven reference clock.
// Assumes the input is asynchronous to clk_i and much slower than it.
`timescale 1ns/1ps
module icsc_sync3 (
  input wire logic clk_i,     // System clock.
  input wire logic reset_n_i, // Synchronous reset, active low.
  input wire logic pin_i,     // Asynchronous input.
  output logic rise_o         // One-cycle pulse per rising edge.
);
  logic meta;
  logic stage2;
  logic stage3;
  logic level;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      meta <= 1'b0;
      stage2 <= 1'b0;
      stage3 <= 1'b0;
      level <= 1'b0;
    end else begin
      meta <= pin_i;
      stage2 <= meta;
      stage3 <= stage2;
      if (stage2 == stage3) begin
        level <= stage3;
      end
    end
  end

  // A change counts only once stages two and three agree, so a sample that
  // resolves late cannot give a short extra pulse.
  assign rise_o = (stage2 == stage3) & stage3 & ~level;
endmodule // icsc_sync3

//--- icsc_tick_div.sv
// Divides a stream of one-cycle ticks by a run-time ratio.
// Assumes a ratio of at least one; the counter restarts when cleared.
`timescale 1ns/1ps
module icsc_tick_div (
  input wire logic clk_i,         // System clock.
  input wire logic reset_n_i,     // Synchronous reset, active low.
  input wire logic clear_i,       // Restart the count.
  input wire logic tick_i,        // Input tick.
  input wire logic [10:0] ratio_i, // Division ratio.
  output logic tick_o             // Every ratio-th input tick.
);
  logic [10:0] count;
  logic last;

  assign last = (count >= (ratio_i - 11'h001));
  assign tick_o = tick_i & last & ~clear_i;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i || clear_i) begin
      count <= 11'h000;
    end else if (tick_i) begin
      count <= last ? 11'h000 : count + 11'h001;
    end
  end
endmodule // icsc_tick_div

//--- icsc_top.sv
// Clock source unit: mode control, FLL model, source select, bus and debug dividers.
// Assumes one 50 MHz clock; every derived clock is a one-cycle enable on clk_i.
// Reference clocks arrive as pins and are synchronised here.
`timescale 1ns/1ps
`include "icsc_defines.svh"
// Functional notes
// - Seven modes: two engaged, two bypassed, two low-power bypassed, and stop.
// - Any reset enters the FLL engaged internal mode without software help.
// - Engaged internal: system clock from FLL on internal reference; debug from FLL.
// - Engaged external: system clock from FLL on external reference; debug from FLL.
// - Bypassed internal: FLL runs on internal reference; system clock is internal.
// - Bypassed internal low power: FLL off, system clock internal, no debug clock.
// - Bypassed external: FLL runs on external reference; system clock is external.
// - Bypassed external low power: FLL off, system clock external, no debug clock.
// - Stop: FLL off, system and debug clocks stop, references follow stop enables.
// - Leaving stop resets oscillator frequency; output stable after acquisition time.
// - Selected source passes a bus divider of 1, 2, 4 or 8 from two bits.
// - Ordinary reset loads factory trims; a debug-entry reset sets all trim bits.
// - Internal reference has nine trim bits: eight coarse plus one fine.
// - Debug clock is the low-range oscillator output divided by two.
// - The FLL offers three oscillators covering different frequency ranges.
// - An option maximises FLL output for a 32768 Hz external reference.
// - Five controls go to the external oscillator: gain, range, request, enable, stop.
// - A low-range oscillator running on stop2 entry keeps running in stop2.
// - A reference divider scales the external reference; its output drives nothing, not the FLL.
// - The unit produces clocks up to 40 MHz, a 20 MHz bus; here the top range ticks at the full 50 MHz and the bus can divide by one.
// - The external oscillator output also clocks the time-of-day counter.
// - Source select 00 FLL, 01 internal, 10 external; 11 acts as 00.
// - Reference select set feeds internal reference to FLL, clear feeds external.
// - Power-down select disables FLL in bypassed modes unless debug is active.
// - Bus divider field resets to divide by two.
module icsc_top (
  input wire logic clk_i,            // 50 MHz system clock.
  input wire logic reset_n_i,        // Synchronous reset, active low.
  input wire logic debug_reset_i,    // Current reset enters background debug mode.
  input wire logic debug_active_i,   // Background debug mode is active.
  input wire logic stop_i,           // Core requests stop.
  input wire logic stop2_i,          // The stop request is stop2.
  input wire logic int_ref_clk_i,    // Internal reference clock pin.
  input wire logic ext_osc_clk_i,    // External oscillator output pin.
  input wire logic [7:0] addr_i,     // Register address.
  input wire logic [7:0] wr_data_i,  // Register write data.
  input wire logic wr_i,             // Write strobe.
  input wire logic rd_i,             // Read strobe.
  output logic [7:0] rd_data_o,      // Read data, cycle after rd_i.
  output logic sys_clk_en_o,         // Selected source tick.
  output logic bus_clk_en_o,         // Bus clock tick after the divider.
  output logic debug_clk_en_o,       // Debug clock tick.
  output logic daytime_clk_en_o,     // Time-of-day counter clock tick.
  output logic fll_enable_o,         // FLL is running.
  output logic fll_locked_o,         // FLL acquisition complete.
  output logic [2:0] mode_o,         // Current operating mode.
  output logic [8:0] ref_trim_o,     // Internal reference trim.
  output logic int_ref_enable_o,     // Internal reference enabled.
  output logic osc_gain_o,           // Oscillator high gain.
  output logic osc_range_o,          // Oscillator high range.
  output logic osc_request_o,        // Oscillator (1) or clock (0) requested.
  output logic ext_ref_enable_o,     // External reference enabled.
  output logic ext_ref_stop_enable_o // External reference stays on in stop.
);
  logic [7:0] ctrl1;
  logic [7:0] ctrl2;
  logic [7:0] coarse_trim;
  logic fine_trim;
  logic dmx32;
  logic [1:0] fll_osc_range;
  icsc_pkg::icsc_mode_type mode;
  icsc_pkg::icsc_mode_type next_mode;
  logic [1:0] clock_source_sel;
  logic [2:0] rdiv;
  logic fll_reference_sel;
  logic [1:0] bus_divider_sel;
  logic fll_power_down_sel;
  logic int_tick;
  logic ext_tick;
  logic ref_div_tick;
  logic fll_tick;
  logic lowrange_tick;
  logic debug_tick;
  logic sys_tick;
  logic fll_on;
  logic stopped;
  logic [10:0] rdiv_ratio;
  logic [10:0] fll_osc_ratio;
  logic [10:0] bus_ratio;
  logic [7:0] acq_count;
  logic prev_ref_sel;
  logic stop2_keep;
  logic ext_en_run;

  assign clock_source_sel = ctrl1[`ICSC_C1_CS_MSB:`ICSC_C1_CS_LSB];
  assign rdiv = ctrl1[`ICSC_C1_RDIV_MSB:`ICSC_C1_RDIV_LSB];
  assign fll_reference_sel = ctrl1[`ICSC_C1_REFSEL];
  assign bus_divider_sel = ctrl2[`ICSC_C2_BUSDIV_MSB:`ICSC_C2_BUSDIV_LSB];
  assign fll_power_down_sel = ctrl2[`ICSC_C2_PWRDN];

  // Register writes; bus divider resets to divide by two.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl1 <= `ICSC_CTRL1_RST;
      ctrl2 <= `ICSC_CTRL2_RST;
      dmx32 <= 1'b0;
      fll_osc_range <= `ICSC_OSCRNG_RST;
    end else if (wr_i) begin
      if (addr_i == `ICSC_ADDR_CTRL1) begin
        ctrl1 <= wr_data_i;
      end
      if (addr_i == `ICSC_ADDR_CTRL2) begin
        ctrl2 <= wr_data_i;
      end
      if (addr_i == `ICSC_ADDR_STAT) begin
        dmx32 <= wr_data_i[`ICSC_ST_DMX32];
        fll_osc_range <= wr_data_i[`ICSC_ST_OSCRNG_MSB:`ICSC_ST_OSCRNG_LSB];
      end
    end
  end

  // Trim loads factory values, or all ones when the reset enters debug.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      coarse_trim <= debug_reset_i ? 8'hff : `ICSC_FACTORY_COARSE;
      fine_trim <= debug_reset_i ? 1'b1 : `ICSC_FACTORY_FINE;
    end else if (wr_i) begin
      if (addr_i == `ICSC_ADDR_TRIM) begin
        coarse_trim <= wr_data_i;
      end
      if (addr_i == `ICSC_ADDR_STAT) begin
        fine_trim <= wr_data_i[`ICSC_ST_FINE];
      end
    end
  end

  assign ref_trim_o = {coarse_trim, fine_trim};

  // Read data stand only in the cycle after the strobe; unmapped reads zero.
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !rd_i) begin
      rd_data_o <= 8'h00;
    end else begin
      case (addr_i)
        `ICSC_ADDR_CTRL1: rd_data_o <= ctrl1;
        `ICSC_ADDR_CTRL2: rd_data_o <= ctrl2;
        `ICSC_ADDR_TRIM: rd_data_o <= coarse_trim;
        `ICSC_ADDR_STAT: rd_data_o <= {fll_osc_range, dmx32, mode, fll_locked_o, fine_trim};
        default: rd_data_o <= 8'h00;
      endcase
    end
  end

  // Mode decode; power-down select is overridden while debug is active.
  always_comb begin
    if (stop_i) begin
      next_mode = icsc_pkg::STOP_MODE;
    end else begin
      case (clock_source_sel)
        2'h1: next_mode = (fll_power_down_sel && !debug_active_i) ?
                          icsc_pkg::BYPASSED_INT_LOWPOWER_MODE :
                          icsc_pkg::FLL_BYPASSED_INT_MODE;
        2'h2: next_mode = (fll_power_down_sel && !debug_active_i) ?
                          icsc_pkg::BYPASSED_EXT_LOWPOWER_MODE :
                          icsc_pkg::FLL_BYPASSED_EXT_MODE;
        default: next_mode = fll_reference_sel ? icsc_pkg::FLL_ENGAGED_INT_MODE :
                             icsc_pkg::FLL_ENGAGED_EXT_MODE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      mode <= icsc_pkg::FLL_ENGAGED_INT_MODE;
    end else begin
      mode <= next_mode;
    end
  end

  assign mode_o = mode;
  assign stopped = (mode == icsc_pkg::STOP_MODE);
  // The FLL runs in every mode but stop and the two low-power ones.
  assign fll_on = !stopped && (mode != icsc_pkg::BYPASSED_INT_LOWPOWER_MODE) &&
                  (mode != icsc_pkg::BYPASSED_EXT_LOWPOWER_MODE);
  assign fll_enable_o = fll_on;

  icsc_sync3 u_int_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(int_ref_clk_i),
    .rise_o(int_tick)
  );

  icsc_sync3 u_ext_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .pin_i(ext_osc_clk_i),
    .rise_o(ext_tick)
  );

  // The oscillator output also clocks the time-of-day counter while enabled.
  assign daytime_clk_en_o = ext_tick & ext_ref_enable_o;

  // Reference divider; the high range starts at 32 and tops out at 1024.
  always_comb begin
    if (!osc_range_o) begin
      rdiv_ratio = 11'h001 << rdiv;
    end else if (rdiv > 3'h5) begin
      rdiv_ratio = `ICSC_RDIV_HI_MAX;
    end else begin
      rdiv_ratio = `ICSC_RDIV_HI_BASE << rdiv;
    end
  end

  icsc_tick_div u_ref_div (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(1'b0),
    .tick_i(ext_tick),
    .ratio_i(rdiv_ratio),
    .tick_o(ref_div_tick)
  );

  // Three oscillator ranges; the 32768 Hz option runs the chosen one at its
  // fastest setting. The top range ticks every cycle, the full 50 MHz clk_i rate.
  always_comb begin
    case (fll_osc_range)
      2'h0: fll_osc_ratio = dmx32 ? `ICSC_OSC_MID_RATIO : `ICSC_OSC_LOW_RATIO;
      2'h1: fll_osc_ratio = dmx32 ? `ICSC_OSC_HIGH_RATIO : `ICSC_OSC_MID_RATIO;
      default: fll_osc_ratio = `ICSC_OSC_HIGH_RATIO;
    endcase
  end

  // Clearing on power-down puts the oscillator back to its reset phase.
  icsc_tick_div u_fll_osc (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(!fll_on),
    .tick_i(1'b1),
    .ratio_i(fll_osc_ratio),
    .tick_o(fll_tick)
  );

  // The low-range oscillator always runs with the FLL and feeds debug.
  icsc_tick_div u_lowrange (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(!fll_on),
    .tick_i(1'b1),
    .ratio_i(`ICSC_OSC_LOW_RATIO),
    .tick_o(lowrange_tick)
  );

  icsc_tick_div u_debug_div (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(!fll_on),
    .tick_i(lowrange_tick),
    .ratio_i(`ICSC_DEBUG_RATIO),
    .tick_o(debug_tick)
  );

  // No debug clock in low-power modes or stop.
  assign debug_clk_en_o = debug_tick & fll_on;

  // Lock needs a full acquisition time after enabling, leaving stop, or
  // switching reference. The count runs on clk_i; reference ticks play no part in it.
  always_ff @(posedge clk_i) begin
    prev_ref_sel <= fll_reference_sel;
    if (!reset_n_i || !fll_on || (prev_ref_sel != fll_reference_sel)) begin
      acq_count <= 8'h00;
    end else if (acq_count != 8'(`ICSC_ACQ_CYCLES)) begin
      acq_count <= acq_count + 8'h01;
    end
  end

  assign fll_locked_o = (acq_count == 8'(`ICSC_ACQ_CYCLES)) && fll_on;

  // Source follows the decoded mode, so the tick always agrees with mode_o.
  always_comb begin
    case (mode)
      icsc_pkg::FLL_BYPASSED_INT_MODE,
      icsc_pkg::BYPASSED_INT_LOWPOWER_MODE: sys_tick = int_tick;
      icsc_pkg::FLL_BYPASSED_EXT_MODE,
      icsc_pkg::BYPASSED_EXT_LOWPOWER_MODE: sys_tick = ext_tick;
      default: sys_tick = fll_tick;
    endcase
  end

  assign sys_clk_en_o = sys_tick & !stopped;
  assign bus_ratio = 11'h001 << bus_divider_sel;

  icsc_tick_div u_bus_div (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .clear_i(stopped),
    .tick_i(sys_clk_en_o),
    .ratio_i(bus_ratio),
    .tick_o(bus_clk_en_o)
  );

  // Internal reference runs when enabled, when it feeds the running FLL, or when selected; in stop only with its stop enable.
  assign int_ref_enable_o = stopped ? (ctrl1[`ICSC_C1_IRCLKEN] & ctrl1[`ICSC_C1_IRSTEN]) :
                            (ctrl1[`ICSC_C1_IRCLKEN] | (fll_on & fll_reference_sel) |
                             (clock_source_sel == 2'h1));

  // A low-range oscillator running at stop2 entry stays on through stop2.
  assign ext_en_run = ctrl2[`ICSC_C2_EREN] | (fll_on & !fll_reference_sel) |
                      (clock_source_sel == 2'h2);
  always_ff @(posedge clk_i) begin
    if (!reset_n_i || !stop_i) begin
      stop2_keep <= 1'b0;
    end else if (!stopped) begin
      stop2_keep <= stop2_i & ext_en_run & !osc_range_o & osc_request_o;
    end
  end

  assign osc_gain_o = ctrl2[`ICSC_C2_GAIN];
  assign osc_range_o = ctrl2[`ICSC_C2_RANGE];
  assign osc_request_o = ctrl2[`ICSC_C2_OSCREQ];
  assign ext_ref_stop_enable_o = ctrl2[`ICSC_C2_ERSTEN];
  assign ext_ref_enable_o = stopped ?
                            ((ctrl2[`ICSC_C2_EREN] & ext_ref_stop_enable_o) | stop2_keep) :
                            ext_en_run;

  a_reset_mode_engaged: assert property (@(posedge clk_i)
    !reset_n_i |=> mode == icsc_pkg::FLL_ENGAGED_INT_MODE)
    else $error("mode not engaged internal after reset");

  a_bus_div_reset: assert property (@(posedge clk_i)
    !reset_n_i |=> bus_divider_sel == 2'h1)
    else $error("bus divider not divide by two after reset");

  a_trim_debug_ones: assert property (@(posedge clk_i)
    (!reset_n_i && debug_reset_i) |=> ref_trim_o == 9'h1ff)
    else $error("trim not set by debug reset");

  a_stop_clocks_off: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    stopped |-> (!sys_clk_en_o && !debug_clk_en_o && !fll_enable_o && !bus_clk_en_o))
    else $error("clock active in stop");

  a_lowpower_no_debug: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (mode == icsc_pkg::BYPASSED_INT_LOWPOWER_MODE ||
     mode == icsc_pkg::BYPASSED_EXT_LOWPOWER_MODE) |-> (!fll_enable_o && !debug_clk_en_o))
    else $error("FLL or debug clock in low power mode");

  a_bypass_int_src: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!stop_i && clock_source_sel == 2'h1 && !fll_power_down_sel) |=>
    (mode == icsc_pkg::FLL_BYPASSED_INT_MODE && sys_clk_en_o == int_tick && fll_enable_o))
    else $error("bypassed internal source wrong");

  a_reserved_src_fll: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (clock_source_sel == 2'h3 && !stop_i) |=> sys_clk_en_o == fll_tick)
    else $error("reserved source code not FLL");

  a_lock_waits_acq: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    $rose(fll_enable_o) |-> !fll_locked_o [*8])
    else $error("lock before acquisition time");

  a_debug_half_rate: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    debug_clk_en_o |=> !debug_clk_en_o [*8])
    else $error("debug clock faster than half low range");

  a_mode_lowpwr_decode: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!stop_i && clock_source_sel == 2'h1 && fll_power_down_sel && !debug_active_i)
    |=> mode == icsc_pkg::BYPASSED_INT_LOWPOWER_MODE)
    else $error("low power bypass not decoded");
endmodule // icsc_top

//--- icsc_ref_model.sv
// Far-side model: the internal reference source and the external crystal oscillator.
// Assumes the clock source unit synchronises both pins itself; the rates are unrelated to clk_i.
`timescale 1ns/1ps
module icsc_ref_model (
  input wire logic osc_enable_i, // External reference enable from the unit.
  output logic int_ref_clk_o,    // Internal reference, free running.
  output logic ext_osc_clk_o     // Oscillator output.
);
  initial int_ref_clk_o = 1'b0;
  initial ext_osc_clk_o = 1'b0;
  // The internal reference never stops, so every internal mode always has a source.
  always #77 int_ref_clk_o = ~int_ref_clk_o;
  // A disabled crystal stops swinging, so stale edges cannot reach the unit.
  always #113 ext_osc_clk_o = osc_enable_i ? ~ext_osc_clk_o : 1'b0;
endmodule // icsc_ref_model

//--- tb_icsc_top.sv
// Self-checking bench for the clock source unit, driven through its register port.
// Assumes the far-side model supplies both reference pins.
`timescale 1ns/1ps
`include "icsc_defines.svh"
module tb_icsc_top;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic debug_reset_i = 1'b0;
  logic debug_active_i = 1'b0;
  logic stop_i = 1'b0;
  logic stop2_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic int_ref_clk, ext_osc_clk, sys_en, bus_en, dbg_en, day_en, fll_en, locked;
  logic gain, range, request, ext_en, ext_sten, int_en;
  logic [7:0] rd_data;
  logic [2:0] mode;
  logic [8:0] trim;
  logic [7:0] rdv;
  int miscompares = 0;
  int checks_done = 0;
  int n_sys, n_bus, n_dbg, n_day;
  always #10 clk_i = ~clk_i;
  icsc_top u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .debug_reset_i(debug_reset_i),
    .debug_active_i(debug_active_i), .stop_i(stop_i), .stop2_i(stop2_i),
    .int_ref_clk_i(int_ref_clk), .ext_osc_clk_i(ext_osc_clk), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data),
    .sys_clk_en_o(sys_en), .bus_clk_en_o(bus_en), .debug_clk_en_o(dbg_en),
    .daytime_clk_en_o(day_en), .fll_enable_o(fll_en), .fll_locked_o(locked), .mode_o(mode),
    .ref_trim_o(trim), .int_ref_enable_o(int_en), .osc_gain_o(gain), .osc_range_o(range),
    .osc_request_o(request), .ext_ref_enable_o(ext_en), .ext_ref_stop_enable_o(ext_sten));
  icsc_ref_model u_ref (.osc_enable_i(ext_en), .int_ref_clk_o(int_ref_clk),
    .ext_osc_clk_o(ext_osc_clk));
  task automatic tally_and_finish();
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [8:0] exp, input logic [8:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Tick counts depend on where the window falls against the tick phase, hence the slack.
  task automatic near(input string what, input int exp, input int got);
    checks_done++;
    if (got < exp - 1 || got > exp + 1) begin
      miscompares++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 rdv = rd_data;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic count(input int n);
    n_sys = 0;
    n_bus = 0;
    n_dbg = 0;
    n_day = 0;
    repeat (n) begin
      @(negedge clk_i);
      n_sys += int'(sys_en);
      n_bus += int'(bus_en);
      n_dbg += int'(dbg_en);
      n_day += int'(day_en);
    end
  endtask
  task automatic wait_lock();
    for (int k = 0; k < 100 && locked !== 1'b1; k++) begin
      settle(1);
    end
    check("fll_locked", 9'h001, 9'(locked));
  endtask
  task automatic do_mode(input logic [7:0] c1, input logic [7:0] c2, input logic dbg,
                         input logic [2:0] m, input logic en);
    wr(`ICSC_ADDR_CTRL2, c2);
    wr(`ICSC_ADDR_CTRL1, c1);
    debug_active_i <= dbg;
    settle(3);
    check("mode", 9'(m), 9'(mode));
    check("fll_enable", 9'(en), 9'(fll_en));
    count(640);
    near("debug ticks", en ? 40 : 0, n_dbg);
  endtask
  initial begin
    #1000000;
    miscompares++;
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    settle(1);
    check("reset mode", 9'h000, 9'(mode));
    check("reset trim", 9'h100, trim);
    check("lock at reset", 9'h000, 9'(locked));
    rd(`ICSC_ADDR_CTRL1);
    check("ctrl1", 9'h004, 9'(rdv));
    rd(`ICSC_ADDR_CTRL2);
    check("ctrl2", 9'h040, 9'(rdv));
    rd(8'h10);
    check("unmapped", 9'h000, 9'(rdv));
    wait_lock();
    do_mode(8'h04, 8'h40, 1'b0, 3'h0, 1'b1);
    do_mode(8'h00, 8'h40, 1'b0, 3'h1, 1'b1);
    do_mode(8'hc4, 8'h40, 1'b0, 3'h0, 1'b1);
    do_mode(8'h44, 8'h40, 1'b0, 3'h3, 1'b1);
    do_mode(8'h44, 8'h48, 1'b0, 3'h2, 1'b0);
    do_mode(8'h84, 8'h40, 1'b0, 3'h6, 1'b1);
    do_mode(8'h84, 8'h48, 1'b0, 3'h7, 1'b0);
    do_mode(8'h84, 8'h48, 1'b1, 3'h6, 1'b1);
    wr(`ICSC_ADDR_CTRL1, 8'h04);
    debug_active_i <= 1'b0;
    for (int b = 0; b < 4; b++) begin
      wr(`ICSC_ADDR_CTRL2, {b[1:0], 6'h00});
      settle(2);
      count(640);
      near("sys ticks", 80, n_sys);
      near("bus ticks", 80 >> b, n_bus);
    end
    wr(`ICSC_ADDR_CTRL2, 8'h77);
    settle(2);
    check("osc controls", 9'h01f, {4'h0, gain, range, request, ext_en, ext_sten});
    check("int ref enable", 9'h001, 9'(int_en));
    wr(`ICSC_ADDR_TRIM, 8'h5a);
    wr(`ICSC_ADDR_STAT, 8'h01);
    settle(2);
    check("trim", 9'h0b5, trim);
    wr(`ICSC_ADDR_STAT, 8'h21);
    settle(2);
    count(640);
    near("fast low range", 160, n_sys);
    wr(`ICSC_ADDR_STAT, 8'h81);
    settle(2);
    count(640);
    near("top range", 640, n_sys);
    wr(`ICSC_ADDR_CTRL2, 8'h42);
    @(posedge clk_i);
    stop_i <= 1'b1;
    settle(2);
    check("stop mode", 9'h005, 9'(mode));
    check("stop fll", 9'h000, {6'h00, int_en, fll_en, ext_en});
    count(200);
    check("stop ticks", 9'h000, 9'(n_sys + n_dbg));
    @(posedge clk_i);
    stop_i <= 1'b0;
    settle(2);
    check("relock start", 9'h000, 9'(locked));
    wait_lock();
    wr(`ICSC_ADDR_CTRL2, 8'h46);
    @(posedge clk_i);
    stop2_i <= 1'b1;
    stop_i <= 1'b1;
    settle(2);
    check("stop2 osc", 9'h001, 9'(ext_en));
    count(640);
    check("stop2 day clock", 9'h001, 9'(n_day > 40 && n_sys == 0));
    @(posedge clk_i);
    stop_i <= 1'b0;
    stop2_i <= 1'b0;
    debug_reset_i <= 1'b1;
    reset_n_i <= 1'b0;
    repeat (8) @(posedge clk_i);
    reset_n_i <= 1'b1;
    debug_reset_i <= 1'b0;
    settle(2);
    check("debug trim", 9'h1ff, trim);
    check("debug reset mode", 9'h000, 9'(mode));
    tally_and_finish();
  end
endmodule // tb_icsc_top
